// *** rtl/ams_pkg.sv ***
// Purpose: Shared constants and types of the mode sequencer
// Assumes: 125 MHz system clock, APB register access
// Notes:   Offsets are byte addresses of 32-bit words
package ams_pkg;

   // ==========================================================
   // Register map
   localparam logic [7:0] OFF_COMM = 8'h00;
   localparam logic [7:0] OFF_MODE = 8'h04;
   localparam logic [7:0] OFF_CONF = 8'h08;
   localparam logic [7:0] OFF_STAT = 8'h0C;
   localparam logic [7:0] OFF_DATA = 8'h10;
   localparam logic [7:0] OFF_PER = 8'h14;
   localparam logic [7:0] OFF_OFS0 = 8'h20;
   localparam logic [7:0] OFF_FSC0 = 8'h30;

   // ==========================================================
   // Reset values
   localparam logic [15:0] RST_MODE = 16'h000A;
   localparam logic [15:0] RST_CONF = 16'h0710;
   localparam logic [31:0] RST_PERIOD = 32'h0003_D090;

   // ==========================================================
   // Field positions and values
   localparam int MODE_LSB = 13;
   localparam int CLKSEL_LSB = 6;
   localparam int GAIN_LSB = 8;
   localparam int CHAN_LSB = 0;
   localparam int COMM_RDREQ = 0;
   localparam int COMM_CREAD = 1;
   localparam logic [1:0] CLKSEL_OUT = 2'h1;
   localparam logic [2:0] GAIN_ONE = 3'h0;

   // ==========================================================
   // Cycle counts
   localparam logic [2:0] CONV_N_FIRST = 3'h2;
   localparam logic [2:0] CONV_N_NEXT = 3'h1;
   localparam logic [2:0] CAL_N_STD = 3'h2;
   localparam logic [2:0] CAL_N_HI = 3'h4;
   localparam int DATA_W = 24;
   localparam int NCH_DEF = 3;
   localparam int CLK_MHZ = 125;
   localparam int SETTLE_MS = 1;
   localparam int SETTLE_CYC = SETTLE_MS * 1000 * CLK_MHZ;

   // ==========================================================
   // Modes and sequencer states
   typedef enum logic [2:0] {
      MD_CONT = 3'h0, MD_SINGLE = 3'h1, MD_IDLE = 3'h2, MD_PDOWN = 3'h3,
      MD_ZS_INT = 3'h4, MD_FS_INT = 3'h5, MD_ZS_SYS = 3'h6, MD_FS_SYS = 3'h7
   } ams_mode_e;

   typedef enum logic [2:0] {
      ST_PDOWN = 3'b000, ST_SETTLE = 3'b001, ST_CONV = 3'b011,
      ST_CAL = 3'b010, ST_IDLE = 3'b110
   } ams_state_e;

endpackage

// *** rtl/ams_shift_if.sv ***
// Purpose: Load handshake between sequencer and serial shifter
// Assumes: Both ends on the system clock
// Notes:   load is a one-cycle pulse
`timescale 1ns/1ps
interface ams_shift_if #(parameter int W = 24);
   logic load;
   logic [W-1:0] word;
   logic busy;
   logic done;
   modport ctrl (output load, output word, input busy, input done);
   modport shft (input load, input word, output busy, output done);
endinterface

// *** rtl/ams_tick.sv ***
// Purpose: Update-period tick generator
// Assumes: len_i sampled at restart and at each tick
// Notes:   tick_o is a one-cycle pulse every len_i cycles
`timescale 1ns/1ps
module ams_tick import ams_pkg::*; (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Control
   input wire logic restart_i,
   input wire logic [31:0] len_i,
   // Event
   output logic tick_o
);
   logic [31:0] cnt;
   logic [31:0] reload;

   // Zero length behaves as one cycle
   assign reload = (len_i == 32'h0) ? 32'h0 : len_i - 32'h1;
   assign tick_o = (cnt == 32'h0) & ~restart_i;

   // Down counter
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt <= RST_PERIOD - 32'h1;
      end else if (restart_i || tick_o) begin
         cnt <= reload;
      end else begin
         cnt <= cnt - 32'h1;
      end
   end

   tick_spacing_a: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      tick_o && len_i > 32'h1 |=> !tick_o)
      else $error("tick repeated inside one period");
endmodule // ams_tick

// *** rtl/ams_shift.sv ***
// Purpose: Serial result shifter on the system clock, stepped by host serial clock edges
// Assumes: Host clock is slow against the system clock
// Notes:   MSB first, next bit after each falling serial edge
`timescale 1ns/1ps
module ams_shift import ams_pkg::*; (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Serial pins
   input wire logic sclk_i,
   output logic dout_o,
   // Load port
   ams_shift_if.shft sh
);
   logic sync1, sync2, sync3;
   logic [DATA_W-1:0] sreg;
   logic [5:0] left;
   logic fall;

   // Edge found only on settled copies
   assign fall = sync3 & ~sync2;
   assign sh.busy = (left != 6'h0);
   assign sh.done = fall & (left == 6'h1);

   // Two-flop synchroniser plus edge history
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sync1 <= 1'b1;
         sync2 <= 1'b1;
         sync3 <= 1'b1;
      end else begin
         sync1 <= sclk_i;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // Shift register; a new load restarts the word
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sreg <= '0;
         left <= 6'h0;
         dout_o <= 1'b0;
      end else if (sh.load) begin
         sreg <= sh.word;
         left <= 6'(DATA_W);
         dout_o <= sh.word[DATA_W-1];
      end else if (fall && sh.busy) begin
         sreg <= {sreg[DATA_W-2:0], 1'b0};
         left <= left - 6'h1;
         dout_o <= sreg[DATA_W-2];
      end
   end

   msb_first_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      sh.load |=> dout_o == $past(sh.word[DATA_W-1]) && sh.busy)
      else $error("first bit not the word's top bit");
endmodule // ams_shift

// *** rtl/ams_seq.sv ***
// Purpose: Operating-mode sequencer of a sigma-delta converter
// Assumes: Filter result arrives on MOD_DATA_I; APB slave, no waits
// Notes:   Host serial clock is sampled, not used as a clock
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps

module ams_seq import ams_pkg::*; #(
   parameter int NCH = NCH_DEF,
   parameter int SETTLE_CYCLES = SETTLE_CYC
) (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RST_B_I,
   // APB slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   // Filter result
   input wire logic [DATA_W-1:0] MOD_DATA_I,
   // Serial port
   input wire logic SCLK_I,
   output logic DOUT_O,
   output logic RDY_B_O,
   // Analog front-end control
   output logic MOD_RST_O,
   output logic MOD_CLK_EN_O,
   output logic PWR_EN_O,
   output logic CLK_OUT_EN_O,
   output logic CAL_SHORT_O,
   output logic CAL_FS_REF_O
);

   // ==========================================================
   // Registers and state
   logic [15:0] mode_reg;
   logic [15:0] conf_reg;
   logic [31:0] period;
   logic cread;
   logic [DATA_W-1:0] data_reg;
   logic rdy_b;
   logic restart_q;
   logic [DATA_W-1:0] ofs [NCH];
   logic [DATA_W-1:0] fsc [NCH];
   ams_state_e state, next_state;
   logic [2:0] cnt, need, next_need;
   logic [31:0] prdata;

   // ==========================================================
   // APB decode
   logic acc, wr, rd, setup_rd;
   logic wr_comm, wr_mode, wr_conf, wr_per, rd_data;
   logic hit_fix, hit_coef, hit;
   logic [1:0] cidx;
   logic cidx_ok;
   logic [3:0] region;

   // Access phase and register hits
   assign acc = PSEL_I & PENABLE_I;
   assign wr = acc & PWRITE_I;
   assign rd = acc & ~PWRITE_I;
   assign setup_rd = PSEL_I & ~PENABLE_I & ~PWRITE_I;
   assign region = PADDR_I[7:4];
   assign cidx = PADDR_I[3:2];
   assign cidx_ok = (32'(cidx) < NCH) && (PADDR_I[1:0] == 2'h0);
   assign hit_coef = cidx_ok &&
      (region == OFF_OFS0[7:4] || region == OFF_FSC0[7:4]);
   assign hit_fix = PADDR_I == OFF_COMM || PADDR_I == OFF_MODE ||
      PADDR_I == OFF_CONF || PADDR_I == OFF_STAT ||
      PADDR_I == OFF_DATA || PADDR_I == OFF_PER;
   assign hit = hit_fix | hit_coef;
   assign wr_comm = wr && PADDR_I == OFF_COMM;
   assign wr_mode = wr && PADDR_I == OFF_MODE;
   assign wr_conf = wr && PADDR_I == OFF_CONF;
   assign wr_per = wr && PADDR_I == OFF_PER;
   assign rd_data = rd && PADDR_I == OFF_DATA;

   // Zero-wait slave; unmapped access answers with an error
   assign PREADY_O = 1'b1;
   assign PSLVERR_O = acc & ~hit;
   assign PRDATA_O = prdata;

   // ==========================================================
   // Field views
   ams_mode_e mode_f, new_mode;
   logic [2:0] gain, chan;
   logic chan_ok;
   logic [1:0] ch;

   // Mode sits in the top three bits of the mode word
   assign mode_f = ams_mode_e'(mode_reg[MODE_LSB+:3]);
   assign new_mode = ams_mode_e'(PWDATA_I[MODE_LSB+:3]);
   assign gain = conf_reg[GAIN_LSB+:3];
   assign chan = conf_reg[CHAN_LSB+:3];
   assign chan_ok = 32'(chan) < NCH;
   assign ch = chan[1:0];

   // ==========================================================
   // Period timer and serial shifter
   logic tick, tmr_restart, restart_evt;
   logic [31:0] tmr_len;
   logic conv_done, cal_done;
   logic rdreq, sh_load;

   // A channel change or any mode write restarts the filter
   assign restart_evt = wr_mode | wr_conf;
   assign tmr_restart = restart_evt; // Settle tick reloads itself
   // Settle interval only when a single conversion is requested
   assign tmr_len = (wr_mode && new_mode == MD_SINGLE) ?
      32'(SETTLE_CYCLES) : period;

   ams_tick u_tick (
      .clk_i(CLK_I),
      .rst_b_i(RST_B_I),
      .restart_i(tmr_restart),
      .len_i(tmr_len),
      .tick_o(tick)
   );

   ams_shift_if #(.W(DATA_W)) sh ();

   ams_shift u_shift (
      .clk_i(CLK_I),
      .rst_b_i(RST_B_I),
      .sclk_i(SCLK_I),
      .dout_o(DOUT_O),
      .sh(sh)
   );

   // Result complete when the needed period count is reached
   assign conv_done = state == ST_CONV && tick && !restart_evt &&
      cnt + 3'h1 == need;
   assign cal_done = state == ST_CAL && tick && !restart_evt &&
      cnt + 3'h1 == need;

   // Continuous read beats a request in the same cycle
   assign rdreq = wr_comm & PWDATA_I[COMM_RDREQ];
   assign sh_load = (conv_done & cread) | rdreq;
   assign sh.load = sh_load;
   assign sh.word = (conv_done & cread) ? MOD_DATA_I : data_reg;

   // ==========================================================
   // Mode decode of a fresh mode word
   always_comb begin
      next_need = CONV_N_FIRST;
      case (new_mode)
         MD_CONT: next_state = ST_CONV;
         MD_SINGLE: next_state = ST_SETTLE;
         MD_IDLE: next_state = ST_IDLE;
         MD_PDOWN: next_state = ST_PDOWN;
         MD_FS_INT: begin
            next_state = ST_CAL;
            // Higher gains need the longer calibration
            next_need = (gain == GAIN_ONE) ? CAL_N_STD : CAL_N_HI;
         end
         MD_ZS_INT, MD_ZS_SYS, MD_FS_SYS: begin
            next_state = ST_CAL;
            next_need = CAL_N_STD;
         end
         default: next_state = ST_IDLE;
      endcase
   end

   // ==========================================================
   // Sequencer
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         state <= ST_CONV;
         cnt <= 3'h0;
         need <= CONV_N_FIRST;
      end else if (wr_mode) begin
         state <= next_state;
         cnt <= 3'h0;
         need <= next_need;
      end else if (wr_conf && state inside {ST_CONV, ST_CAL}) begin
         cnt <= 3'h0;
         need <= (state == ST_CONV) ? CONV_N_FIRST : need;
      end else begin
         case (state)
            ST_SETTLE: begin
               if (tick) begin
                  state <= ST_CONV;
                  cnt <= 3'h0;
                  need <= CONV_N_FIRST;
               end
            end
            ST_CONV: begin
               if (conv_done) begin
                  cnt <= 3'h0;
                  need <= CONV_N_NEXT;
                  if (mode_f == MD_SINGLE) begin
                     state <= ST_PDOWN;
                  end
               end else if (tick) begin
                  cnt <= cnt + 3'h1;
               end
            end
            ST_CAL: begin
               if (cal_done) begin
                  state <= ST_IDLE;
               end else if (tick) begin
                  cnt <= cnt + 3'h1;
               end
            end
            ST_IDLE, ST_PDOWN: cnt <= 3'h0;
            default: state <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Host-visible registers
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         mode_reg <= RST_MODE;
         conf_reg <= RST_CONF;
         period <= RST_PERIOD;
         cread <= 1'b0;
         restart_q <= 1'b0;
      end else begin
         restart_q <= restart_evt;
         if (wr_mode) begin
            mode_reg <= PWDATA_I[15:0];
         end else if (cal_done) begin
            mode_reg[MODE_LSB+:3] <= MD_IDLE;
         end
         if (wr_conf) begin
            conf_reg <= PWDATA_I[15:0];
         end
         if (wr_per) begin
            period <= PWDATA_I;
         end
         if (wr_comm) begin
            cread <= PWDATA_I[COMM_CREAD];
         end
      end
   end

   // Result and done flag; a finishing conversion beats a clear
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         data_reg <= '0;
         rdy_b <= 1'b1;
      end else if (conv_done || cal_done) begin
         rdy_b <= 1'b0;
         if (conv_done) begin
            data_reg <= MOD_DATA_I;
         end
      end else if (wr_mode) begin
         rdy_b <= 1'b1;
      end else if (rd_data || sh.done) begin
         rdy_b <= 1'b1;
      end
   end

   // Per-channel coefficient stores
   generate
      for (genvar i = 0; i < NCH; i++) begin : g_coef
         logic sel;
         assign sel = cal_done && chan_ok && 32'(ch) == i;
         always_ff @(posedge CLK_I or negedge RST_B_I) begin
            if (!RST_B_I) begin
               ofs[i] <= '0;
               fsc[i] <= '0;
            end else if (sel) begin
               if (mode_f == MD_ZS_INT || mode_f == MD_ZS_SYS) begin
                  ofs[i] <= MOD_DATA_I;
               end else begin
                  fsc[i] <= MOD_DATA_I;
               end
            end
         end
      end
   endgenerate

   // ==========================================================
   // Read data, captured in the setup cycle
   logic [31:0] rd_mux;
   assign rd_mux =
      (PADDR_I == OFF_COMM) ? {30'h0, cread, 1'b0} :
      (PADDR_I == OFF_MODE) ? {16'h0, mode_reg} :
      (PADDR_I == OFF_CONF) ? {16'h0, conf_reg} :
      (PADDR_I == OFF_STAT) ? {25'h0, chan, state, rdy_b} :
      (PADDR_I == OFF_DATA) ? {8'h0, data_reg} :
      (PADDR_I == OFF_PER) ? period :
      (hit_coef && region == OFF_OFS0[7:4]) ? {8'h0, ofs[cidx]} :
      (hit_coef) ? {8'h0, fsc[cidx]} : 32'h0;

   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         prdata <= 32'h0;
      end else if (setup_rd) begin
         prdata <= rd_mux;
      end
   end

   // ==========================================================
   // Front-end controls
   // Filter held in reset in idle, power-down and settling, and after restarts
   assign MOD_RST_O = restart_q ||
      state inside {ST_IDLE, ST_PDOWN, ST_SETTLE};
   assign MOD_CLK_EN_O = state != ST_PDOWN;
   assign PWR_EN_O = state != ST_PDOWN;
   assign CLK_OUT_EN_O = state != ST_PDOWN &&
      mode_reg[CLKSEL_LSB+:2] == CLKSEL_OUT;
   assign CAL_SHORT_O = state == ST_CAL && mode_f == MD_ZS_INT;
   assign CAL_FS_REF_O = state == ST_CAL && mode_f == MD_FS_INT;
   assign RDY_B_O = rdy_b;

   // ==========================================================
   // Checks
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_B_I);

   // Ticks seen since the last restart or settle tick, saturating
   logic [2:0] ticks_since;
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         ticks_since <= 3'h0;
      end else if (tmr_restart || (state == ST_SETTLE && tick)) begin
         ticks_since <= 3'h0;
      end else if (tick && ticks_since != 3'h7) begin
         ticks_since <= ticks_since + 3'h1;
      end
   end

   sequence s_mode_write;
      wr_mode;
   endsequence
   sequence s_filter_reset;
      RDY_B_O && MOD_RST_O;
   endsequence

   done_low_a: assert property (
      conv_done |=> !RDY_B_O && data_reg == $past(MOD_DATA_I))
      else $error("result not stored or done not low");
   stream_load_a: assert property (
      conv_done && cread |=> sh.busy && DOUT_O == $past(MOD_DATA_I[23]))
      else $error("continuous read did not start shifting");
   read_req_a: assert property (
      rdreq && !conv_done |=> sh.busy && DOUT_O == $past(data_reg[23]))
      else $error("read request did not start shifting");
   first_two_a: assert property (
      conv_done && need == CONV_N_FIRST |-> ticks_since == 3'h1)
      else $error("first result not after two periods");
   single_end_a: assert property (
      conv_done && mode_f == MD_SINGLE |=> state == ST_PDOWN && !RDY_B_O)
      else $error("single conversion did not power down");
   single_hold_a: assert property (
      state == ST_PDOWN && !RDY_B_O && !wr_mode && !rd_data && !sh.done
      |=> !RDY_B_O)
      else $error("done flag dropped without a read");
   idle_clk_a: assert property (
      state == ST_IDLE |-> MOD_RST_O && MOD_CLK_EN_O)
      else $error("idle must reset filter and keep clocks");
   pdown_off_a: assert property (
      state == ST_PDOWN |-> !PWR_EN_O && !CLK_OUT_EN_O && !MOD_CLK_EN_O)
      else $error("power-down left circuitry on");
   cal_idle_a: assert property (
      cal_done |=> state == ST_IDLE && mode_f == MD_IDLE && !RDY_B_O)
      else $error("calibration did not end in idle");
   cal_length_a: assert property (
      cal_done |-> ticks_since + 3'h1 == need)
      else $error("calibration length wrong");
   mode_wr_a: assert property (
      s_mode_write |=> s_filter_reset)
      else $error("mode write did not reset filter");
endmodule // ams_seq

// *** test/ams_host_model.sv ***
// Purpose: Host side of the three-wire serial port
// Assumes: Caller starts a frame once the first bit is on the data line
// Notes:   Serial clock idles high and stands still between frames
`timescale 1ns/1ps
module ams_host_model import ams_pkg::*; (
   // Serial pins
   input wire logic dout_i,
   output logic sclk_o
);
   // ==========================================================
   // Idle level
   initial sclk_o = 1'b1;

   // One word MSB first; sampled just before each falling edge, so
   // the device has a full high phase to settle the next bit
   task automatic frame(input realtime h, output logic [DATA_W-1:0] w);
      for (int i = 0; i < DATA_W; i++) begin
         w = {w[DATA_W-2:0], dout_i};
         sclk_o = 1'b0;
         #h;
         sclk_o = 1'b1;
         #h;
      end
   endtask
endmodule // ams_host_model

// *** test/adc_operating_mode_sequencer_tb_top.sv ***
// Purpose: Self-checking bench of the operating-mode sequencer
// Assumes: Short settle time and update period for simulation
// Notes:   Coefficients are tracked in a small model array
`timescale 1ns/1ps
module adc_operating_mode_sequencer_tb_top import ams_pkg::*; ;
   // ==========================================================
   // Signals and model state
   localparam int SETTLE = 20;
   logic clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rv;
   logic [DATA_W-1:0] mod_data, w;
   logic dout, sclk, rdy_b, mod_rst, mod_clk_en, pwr_en, clk_out_en;
   logic cal_short, cal_fs_ref;
   int miscompares, tests_run, n, p, j;
   logic [31:0] coef[6];
   bit known[6];
   ams_mode_e cm[5] = '{MD_ZS_INT, MD_FS_INT, MD_FS_INT, MD_ZS_SYS, MD_FS_SYS};
   int cc[5] = '{0, 1, 2, 2, 0};
   int cg[5] = '{0, 0, 3, 0, 7};
   int cn[5] = '{2, 2, 4, 2, 2};

   // Design and host
   ams_seq #(.SETTLE_CYCLES(SETTLE)) dut_u (
      .CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(penable),
      .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
      .MOD_DATA_I(mod_data), .SCLK_I(sclk), .DOUT_O(dout),
      .RDY_B_O(rdy_b), .MOD_RST_O(mod_rst), .MOD_CLK_EN_O(mod_clk_en),
      .PWR_EN_O(pwr_en), .CLK_OUT_EN_O(clk_out_en),
      .CAL_SHORT_O(cal_short), .CAL_FS_REF_O(cal_fs_ref));
   ams_host_model host_u (.dout_i(dout), .sclk_o(sclk));

   // Clock
   always #4 clk = ~clk;

   // ==========================================================
   // Helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // A wait that runs out counts as a mismatch
   task automatic tmo();
      check(32'h0, 32'h1);
      results();
   endtask

   // APB transfer; one idle edge after it so strobes never toggle twice
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
         if (k > 50) tmo();
      end while (pready !== 1'b1);
      rv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   // Cycles until the done flag falls, left in n
   task automatic wait_rdy(input int lim);
      n = 0;
      while (rdy_b !== 1'b0) begin
         @(posedge clk);
         n++;
         if (n > lim) tmo();
      end
   endtask

   task automatic new_data();
      mod_data <= DATA_W'($urandom);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, mod_data} = '0;
      miscompares = 0;
      tests_run = 0;
      void'($urandom(32'hE2DB));
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      apb(1'b0, OFF_MODE, 32'h0);
      check(rv, 32'(RST_MODE));
      apb(1'b0, 8'h40, 32'h0);
      check(err, 1'b1);
      check(rv, 32'h0);
      // Continuous conversions, first after two periods
      p = 10;
      apb(1'b1, OFF_PER, 32'(p));
      new_data();
      apb(1'b1, OFF_MODE, 32'h0000_0040);
      check(rdy_b, 1'b1);
      for (int i = 0; i < 3; i++) begin
         wait_rdy(100);
         check((n + 5) / p, i == 0 ? 2 : 1);
         apb(1'b0, OFF_DATA, 32'h0);
         check(rv, 32'(mod_data));
         new_data();
      end
      // Single conversion, then read request over the serial port
      apb(1'b1, OFF_MODE, 32'(MD_SINGLE) << MODE_LSB);
      wait_rdy(200);
      check((n + 5 - SETTLE) / p, 2);
      @(posedge clk);
      check(pwr_en, 1'b0);
      repeat (40) @(posedge clk);
      check(rdy_b, 1'b0);
      apb(1'b1, OFF_COMM, 32'h1);
      repeat (2) @(posedge clk);
      host_u.frame(62.5, w);
      check(w, mod_data);
      repeat (5) @(posedge clk);
      check(rdy_b, 1'b1);
      apb(1'b0, OFF_DATA, 32'h0);
      check(rv, 32'(mod_data));
      // Idle keeps clocks; power-down switches all off
      apb(1'b1, OFF_MODE, 32'h0000_4040);
      check(mod_rst, 1'b1);
      check(mod_clk_en, 1'b1);
      check(clk_out_en, 1'b1);
      apb(1'b1, OFF_MODE, 32'h0000_6040);
      check(pwr_en, 1'b0);
      check(mod_clk_en, 1'b0);
      check(clk_out_en, 1'b0);
      // Every calibration mode, across channels and gains
      for (int k = 0; k < 5; k++) begin
         apb(1'b1, OFF_CONF, 32'(cg[k] * 256 + cc[k]));
         new_data();
         apb(1'b1, OFF_MODE, 32'(cm[k]) << MODE_LSB);
         check(rdy_b, 1'b1);
         check(cal_short, cm[k] == MD_ZS_INT);
         check(cal_fs_ref, cm[k] == MD_FS_INT);
         wait_rdy(100);
         check((n + 5) / p, cn[k]);
         j = cc[k] + (cm[k][0] ? 3 : 0);
         coef[j] = 32'(mod_data);
         known[j] = 1'b1;
         apb(1'b0, OFF_MODE, 32'h0);
         check(rv[15:13], MD_IDLE);
         apb(1'b0, OFF_STAT, 32'h0);
         check(rv, 32'(cc[k] * 16 + 12));
         for (int i = 0; i < 6; i++) begin
            apb(1'b0, (i < 3 ? OFF_OFS0 : OFF_FSC0) + 8'(4 * (i % 3)), 0);
            if (known[i])
               check(rv, coef[i]);
         end
      end
      // Continuous read: period long enough for a whole frame
      p = 600;
      apb(1'b1, OFF_PER, 32'(p));
      apb(1'b1, OFF_COMM, 32'h2);
      new_data();
      apb(1'b1, OFF_MODE, 32'h0);
      wait_rdy(1500);
      repeat (2) @(posedge clk);
      host_u.frame(62.5, w);
      check(w, mod_data);
      @(posedge clk);
      apb(1'b1, OFF_COMM, 32'h0);
      results();
   end
endmodule // adc_operating_mode_sequencer_tb_top
